// >>> hw/rsso_pkg.sv
// constants, register map and operation codes for the rotate/set/sleep/subtract executor
package rsso_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFS_INSTR = 6'h00;
  localparam logic [5:0] OFS_ACC = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_POWER = 6'h0c;
  localparam logic [5:0] OFS_BANK = 6'h10;
  localparam logic [5:0] OFS_INDEX = 6'h14;
  localparam logic [5:0] OFS_CTRL = 6'h18;
  localparam logic [5:0] OFS_MEMADDR = 6'h1c;
  localparam logic [5:0] OFS_MEMDATA = 6'h20;

  // status field positions
  localparam int C_BIT = 0;
  localparam int DC_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int OV_BIT = 3;
  localparam int N_BIT = 4;

  // power field positions
  localparam int PD_N_BIT = 0;
  localparam int TO_N_BIT = 1;
  localparam int ASLEEP_BIT = 2;
  localparam int BUSY_BIT = 3;

  // control field positions
  localparam int EXT_EN_BIT = 0;

  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] INDEX_RESET = 12'h000;

  // opcode patterns
  localparam logic [5:0] OPC_ROTATE = 6'h10;
  localparam logic [6:0] OPC_SETONES = 7'h34;
  localparam logic [15:0] OPC_SLEEP = 16'h0003;
  localparam logic [5:0] OPC_SUBBORROW = 6'h15;
  localparam logic [7:0] OPC_SUBLIT = 8'h08;
  localparam logic [5:0] OPC_SUBREG = 6'h17;

  // operand bit positions in the instruction word
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;

  // access bank layout and memory size
  localparam logic [7:0] ACCESS_SPLIT = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam int MEM_DEPTH = 4096;

  // one instruction cycle takes this many core clocks
  localparam int PHASES_PER_CYCLE = 4;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_ROTATE,
    OP_SETONES,
    OP_SLEEP,
    OP_SUBBORROW,
    OP_SUBLIT,
    OP_SUBREG
  } rsso_op_t;

endpackage

// >>> hw/rsso_alu.sv
// byte datapath for rotate, set and the three subtract forms
module rsso_alu (
  // operation and operands
  input wire rsso_pkg::rsso_op_t op,
  input wire logic [7:0] fileVal,
  input wire logic [7:0] accVal,
  input wire logic [7:0] litVal,
  input wire logic carryIn,
  // result and flags
  output logic [7:0] result,
  output logic negFlag,
  output logic ovFlag,
  output logic zeroFlag,
  output logic dcFlag,
  output logic carryFlag
);

  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic addIn;
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic [7:0] rotated;

  // pick minuend, subtrahend and the incoming inverted borrow
  always_comb begin
    minuend = fileVal;
    subtrahend = accVal;
    addIn = 1'b1;
    case (op)
      // RL10: w minus f minus not carry
      rsso_pkg::OP_SUBBORROW: begin
        minuend = accVal;
        subtrahend = fileVal;
        addIn = carryIn;
      end
      // RL11: literal minus w
      rsso_pkg::OP_SUBLIT: begin
        minuend = litVal;
        subtrahend = accVal;
      end
      // RL12: f minus w
      default: begin
        minuend = fileVal;
        subtrahend = accVal;
      end
    endcase
  end

  // RL13: subtract as add of complement, carry out is the inverted borrow
  assign sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, addIn};
  assign lowSum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, addIn};
  // RL1: bit n to n-1, bit 0 to bit 7, carry not involved
  assign rotated = {fileVal[0], fileVal[7:1]};

  // result select
  always_comb begin
    case (op)
      rsso_pkg::OP_ROTATE: result = rotated;
      rsso_pkg::OP_SETONES: result = rsso_pkg::ALL_ONES;
      rsso_pkg::OP_SUBBORROW, rsso_pkg::OP_SUBLIT, rsso_pkg::OP_SUBREG: result = sum[7:0];
      default: result = fileVal;
    endcase
  end

  // RL15: zero and negative taken from the two's complement byte
  assign zeroFlag = (result == 8'h00);
  assign negFlag = result[7];
  assign carryFlag = sum[8];
  assign dcFlag = lowSum[4];
  // signed overflow: operands of unlike sign and result sign differs from minuend
  assign ovFlag = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ sum[7]);

endmodule

// >>> hw/rsso_exec.sv
// executor for rotate, set-all-ones, sleep and subtract instructions behind an avalon slave
// Summary of operation
// RL1: rotate right moves bit n to n-1 and bit 0 to bit 7, carry untouched.
// RL2: rotate right updates only negative and zero flags.
// RL3: destination bit 0 writes accumulator, 1 writes the file register.
// RL4: access bit 0 uses access bank; 1 uses bank select register.
// RL5: access bit 0, extension on, address up to 95: indexed literal offset.
// RL6: set-all-ones writes FFh to the file register, flags unchanged.
// RL7: sleep clears power-down flag, sets time-out flag, clears watchdog and postscaler.
// RL8: after sleep the oscillator stops and execution halts in phase four.
// RL9: watchdog wake clears the time-out flag; other wakes leave it set.
// RL10: subtract with borrow: accumulator minus register minus inverted carry, five flags.
// RL11: literal minus accumulator, always into accumulator, five flags.
// RL12: register minus accumulator, stored per destination bit, five flags.
// RL13: carry is inverted borrow: one for positive or zero, zero on borrow.
// RL14: each instruction is one word and one cycle of four phases.
// RL15: zero result sets zero flag; negative results show as two's complement byte.
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
module rsso_exec (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // wake sources and power control
  input wire logic wakeWatchdog,
  input wire logic wakeOther,
  output logic watchdogClear,
  output logic oscRun
);

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } rsso_phase_t;

  rsso_phase_t phase_q;
  rsso_phase_t phase_d;

  // architectural state
  logic [7:0] acc_q;
  logic [4:0] status_q;
  logic [3:0] bank_q;
  logic [11:0] index_q;
  logic extEn_q;
  logic [11:0] memAddr_q;
  logic pdN_q;
  logic toN_q;
  logic asleep_q;
  logic watchdogClear_q;
  logic [7:0] mem [rsso_pkg::MEM_DEPTH];

  // pipeline state of the running instruction
  logic [15:0] instr_q;
  rsso_pkg::rsso_op_t op_q;
  logic [11:0] fileAddr_q;
  logic [7:0] operand_q;
  logic [7:0] result_q;
  logic [4:0] flags_q;

  // bus read path
  logic readDone_q;
  logic [31:0] readData_q;

  // bus decode
  wire busy = (phase_q != PH_IDLE);
  wire [31:0] beMask;
  wire [31:0] wrMerge;
  wire hitInstr = (avsAddress == rsso_pkg::OFS_INSTR);
  wire hitAcc = (avsAddress == rsso_pkg::OFS_ACC);
  wire hitStatus = (avsAddress == rsso_pkg::OFS_STATUS);
  wire hitPower = (avsAddress == rsso_pkg::OFS_POWER);
  wire hitBank = (avsAddress == rsso_pkg::OFS_BANK);
  wire hitIndex = (avsAddress == rsso_pkg::OFS_INDEX);
  wire hitCtrl = (avsAddress == rsso_pkg::OFS_CTRL);
  wire hitMemAddr = (avsAddress == rsso_pkg::OFS_MEMADDR);
  wire hitMemData = (avsAddress == rsso_pkg::OFS_MEMDATA);
  // writes stall while an instruction runs so bus and core never race on state
  wire wrStall = avsWrite & busy;
  wire wrTake = avsWrite & ~busy;
  // instructions offered during sleep are dropped: execution is halted
  wire startInstr = wrTake & hitInstr & ~asleep_q;

  // byte lane mask, one lane per byteenable bit
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : gLane
      assign beMask[lane*8 +: 8] = {8{avsByteenable[lane]}};
    end
  endgenerate

  // read answers one cycle after the request, write answers at once unless busy
  assign avsWaitrequest = (avsRead & ~readDone_q) | wrStall;
  assign avsReaddata = readData_q;
  assign watchdogClear = watchdogClear_q;
  // RL8: oscillator enable drops while asleep
  assign oscRun = ~asleep_q;

  // current value of the addressed register, used for reads and lane merging
  logic [31:0] regView;
  always_comb begin
    regView = 32'h0000_0000;
    if (hitInstr) begin
      regView = {16'h0000, instr_q};
    end else if (hitAcc) begin
      regView = {24'h00_0000, acc_q};
    end else if (hitStatus) begin
      regView = {27'h0, status_q};
    end else if (hitPower) begin
      regView = {28'h000_0000, busy, asleep_q, toN_q, pdN_q};
    end else if (hitBank) begin
      regView = {28'h000_0000, bank_q};
    end else if (hitIndex) begin
      regView = {20'h0_0000, index_q};
    end else if (hitCtrl) begin
      regView = {31'h0, extEn_q};
    end else if (hitMemAddr) begin
      regView = {20'h0_0000, memAddr_q};
    end else if (hitMemData) begin
      regView = {24'h00_0000, mem[memAddr_q]};
    end
  end

  assign wrMerge = (regView & ~beMask) | (avsWritedata & beMask);

  // decode of the offered instruction word
  wire [15:0] newInstr = wrMerge[15:0];
  rsso_pkg::rsso_op_t newOp;
  always_comb begin
    if (newInstr == rsso_pkg::OPC_SLEEP) begin
      newOp = rsso_pkg::OP_SLEEP;
    end else if (newInstr[15:10] == rsso_pkg::OPC_ROTATE) begin
      newOp = rsso_pkg::OP_ROTATE;
    end else if (newInstr[15:9] == rsso_pkg::OPC_SETONES) begin
      newOp = rsso_pkg::OP_SETONES;
    end else if (newInstr[15:10] == rsso_pkg::OPC_SUBBORROW) begin
      newOp = rsso_pkg::OP_SUBBORROW;
    end else if (newInstr[15:8] == rsso_pkg::OPC_SUBLIT) begin
      newOp = rsso_pkg::OP_SUBLIT;
    end else if (newInstr[15:10] == rsso_pkg::OPC_SUBREG) begin
      newOp = rsso_pkg::OP_SUBREG;
    end else begin
      newOp = rsso_pkg::OP_NOP;
    end
  end

  // file address resolution
  wire [7:0] fField = instr_q[7:0];
  wire accessBit = instr_q[rsso_pkg::ACCESS_BIT];
  wire destBit = instr_q[rsso_pkg::DEST_BIT];
  wire lowAccess = (fField <= rsso_pkg::ACCESS_SPLIT);
  // RL5: indexed literal offset adds the literal to the index base
  wire [11:0] indexedAddr = index_q + {4'h0, fField};
  wire [11:0] accessAddr = lowAccess ? {rsso_pkg::ACCESS_LOW_BANK, fField} : {rsso_pkg::ACCESS_HIGH_BANK, fField};
  wire [11:0] bankedAddr = {bank_q, fField};
  // RL4: access bit picks access bank or the bank select register
  wire [11:0] resolvedAddr = accessBit ? bankedAddr : ((extEn_q & lowAccess) ? indexedAddr : accessAddr);

  // alu on the latched operand
  logic [7:0] aluResult;
  logic aluN;
  logic aluOv;
  logic aluZ;
  logic aluDc;
  logic aluC;
  rsso_alu i_rsso_alu (
    .op(op_q),
    .fileVal(operand_q),
    .accVal(acc_q),
    .litVal(fField),
    .carryIn(status_q[rsso_pkg::C_BIT]),
    .result(aluResult),
    .negFlag(aluN),
    .ovFlag(aluOv),
    .zeroFlag(aluZ),
    .dcFlag(aluDc),
    .carryFlag(aluC)
  );

  // RL14: one instruction cycle walks decode, read, process, write
  always_comb begin
    case (phase_q)
      PH_IDLE: phase_d = startInstr ? PH_DECODE : PH_IDLE;
      PH_DECODE: phase_d = PH_READ;
      PH_READ: phase_d = PH_PROCESS;
      PH_PROCESS: phase_d = PH_WRITE;
      PH_WRITE: phase_d = PH_IDLE;
      default: phase_d = PH_IDLE;
    endcase
  end

  wire inWrite = (phase_q == PH_WRITE);
  wire isSub = (op_q == rsso_pkg::OP_SUBBORROW) | (op_q == rsso_pkg::OP_SUBLIT) | (op_q == rsso_pkg::OP_SUBREG);
  // RL11: literal subtract always lands in the accumulator
  wire toAcc = (op_q == rsso_pkg::OP_SUBLIT) | (((op_q == rsso_pkg::OP_ROTATE) | isSub) & ~destBit);
  // RL3: destination bit one writes back to the file register
  wire toFile = (op_q == rsso_pkg::OP_SETONES) | (((op_q == rsso_pkg::OP_ROTATE) | isSub) & destBit & (op_q != rsso_pkg::OP_SUBLIT));

  // next status: the running instruction wins over a same-cycle bus write
  logic [4:0] status_d;
  always_comb begin
    status_d = status_q;
    if (wrTake & hitStatus) begin
      status_d = wrMerge[4:0];
    end
    if (inWrite & isSub) begin
      // RL10: five flags from the subtraction
      status_d = flags_q;
    end else if (inWrite & (op_q == rsso_pkg::OP_ROTATE)) begin
      // RL2: only negative and zero follow the rotate
      status_d[rsso_pkg::N_BIT] = flags_q[rsso_pkg::N_BIT];
      status_d[rsso_pkg::Z_BIT] = flags_q[rsso_pkg::Z_BIT];
    end
  end

  // phase and instruction capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_q <= PH_IDLE;
      instr_q <= 16'h0000;
      op_q <= rsso_pkg::OP_NOP;
    end else begin
      phase_q <= phase_d;
      if (startInstr) begin
        instr_q <= newInstr;
        op_q <= newOp;
      end
    end
  end

  // operand read in phase two, process in phase three
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fileAddr_q <= 12'h000;
      operand_q <= 8'h00;
      result_q <= 8'h00;
      flags_q <= 5'h00;
    end else begin
      if (phase_q == PH_READ) begin
        fileAddr_q <= resolvedAddr;
        operand_q <= mem[resolvedAddr];
      end
      if (phase_q == PH_PROCESS) begin
        result_q <= aluResult;
        flags_q <= {aluN, aluOv, aluZ, aluDc, aluC};
      end
    end
  end

  // accumulator and status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_q <= rsso_pkg::ACC_RESET;
      status_q <= rsso_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
      if (inWrite & toAcc) begin
        acc_q <= result_q;
      end else if (wrTake & hitAcc) begin
        acc_q <= wrMerge[7:0];
      end
    end
  end

  // software configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_q <= rsso_pkg::BANK_RESET;
      index_q <= rsso_pkg::INDEX_RESET;
      extEn_q <= 1'b0;
      memAddr_q <= 12'h000;
    end else if (wrTake) begin
      if (hitBank) begin
        bank_q <= wrMerge[3:0];
      end
      if (hitIndex) begin
        index_q <= wrMerge[11:0];
      end
      if (hitCtrl) begin
        extEn_q <= wrMerge[rsso_pkg::EXT_EN_BIT];
      end
      if (hitMemAddr) begin
        memAddr_q <= wrMerge[11:0];
      end
    end
  end

  // file memory: the core writes only in phase four, the bus only while idle
  always_ff @(posedge clk_sys) begin
    if (inWrite & toFile) begin
      // RL6: set-all-ones result is FFh from the alu
      mem[fileAddr_q] <= result_q;
    end else if (wrTake & hitMemData) begin
      mem[memAddr_q] <= wrMerge[7:0];
    end
  end

  // sleep entry and wake; entry in the same cycle as a wake wins, halting first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdN_q <= 1'b1;
      toN_q <= 1'b1;
      asleep_q <= 1'b0;
      watchdogClear_q <= 1'b0;
    end else begin
      watchdogClear_q <= 1'b0;
      if (inWrite & (op_q == rsso_pkg::OP_SLEEP)) begin
        // RL7: flags and watchdog clear on sleep
        pdN_q <= 1'b0;
        toN_q <= 1'b1;
        watchdogClear_q <= 1'b1;
        // RL8: halt in the write phase
        asleep_q <= 1'b1;
      end else if (asleep_q & (wakeWatchdog | wakeOther)) begin
        asleep_q <= 1'b0;
        // RL9: only a watchdog wake clears the time-out flag
        if (wakeWatchdog) begin
          toN_q <= 1'b0;
        end
      end
    end
  end

  // registered read data, waitrequest drops one cycle after read rises
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readDone_q <= 1'b0;
      readData_q <= 32'h0000_0000;
    end else begin
      readDone_q <= avsRead & ~readDone_q;
      if (avsRead & ~readDone_q) begin
        readData_q <= regView;
      end
    end
  end

endmodule

// >>> verif/rsso_exec_chk.sv
// port-level assertions for the rotate/set/sleep/subtract executor
module rsso_exec_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon slave
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  // wake and power
  input wire logic wakeWatchdog,
  input wire logic wakeOther,
  input wire logic watchdogClear,
  input wire logic oscRun
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // instruction word accepted while awake; instruction writes while asleep are dropped
  wire instrTaken = avsWrite && !avsWaitrequest && avsAddress == rsso_pkg::OFS_INSTR && oscRun;
  wire sleepTaken = instrTaken && avsByteenable[1:0] == 2'h3 && avsWritedata[15:0] == rsso_pkg::OPC_SLEEP;
  wire wakeAny = wakeWatchdog || wakeOther;

  // sleep entry: four phases still running, then halted with one clear pulse
  sequence s_phases;
    oscRun [*5];
  endsequence
  sequence s_halted;
    !oscRun && watchdogClear;
  endsequence

  a_read_one_wait: assert property ($rose(avsRead) |-> avsWaitrequest ##1 !avsWaitrequest)
    else $error("read wait state count wrong");
  a_instr_busy: assert property (instrTaken |=> (!avsWrite || avsWaitrequest) [*4])
    else $error("write accepted during instruction cycle");
  a_sleep_entry: assert property (sleepTaken |-> s_phases ##1 s_halted)
    else $error("sleep entry timing wrong");
  a_clear_once: assert property (watchdogClear |=> !watchdogClear)
    else $error("watchdog clear longer than one cycle");
  a_clear_cause: assert property (watchdogClear |-> $past(oscRun) && !oscRun)
    else $error("watchdog clear without sleep entry");
  a_osc_fall: assert property ($fell(oscRun) |-> watchdogClear)
    else $error("oscillator stopped without sleep");
  a_wake_resume: assert property (!oscRun && wakeAny |=> oscRun)
    else $error("wake did not restart oscillator");
  a_sleep_hold: assert property (!oscRun && !wakeAny |=> !oscRun)
    else $error("left sleep without wake");
  a_data_stands: assert property (!avsRead |=> $stable(avsReaddata))
    else $error("read data changed without read");
endmodule

bind rsso_exec rsso_exec_chk i_rsso_exec_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .avsAddress(avsAddress),
  .avsRead(avsRead),
  .avsWrite(avsWrite),
  .avsWritedata(avsWritedata),
  .avsByteenable(avsByteenable),
  .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest),
  .wakeWatchdog(wakeWatchdog),
  .wakeOther(wakeOther),
  .watchdogClear(watchdogClear),
  .oscRun(oscRun)
);

// >>> verif/rsso_exec_tb.sv
// self-checking bench for the rotate/set/sleep/subtract executor
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module rsso_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [15:0] ins;
    logic [7:0] acc, fv;
    logic [4:0] st;
    logic [7:0] eAcc, eFile;
    logic [4:0] eSt;
  } rsso_case_t;
  logic clk_sys, rst, avsRead, avsWrite, avsWaitrequest, wakeWatchdog, wakeOther, watchdogClear, oscRun;
  logic [5:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic [3:0] avsByteenable, clearCount;
  int mismatches = 0;
  int testsRun = 0;
  int cycles = 0;
  rsso_case_t cases [13];
  logic [15:0] adrIns [4] = '{16'h6980, 16'h6880, 16'h685f, 16'h6860};
  logic [11:0] adrTgt [4] = '{12'h280, 12'hf80, 12'h15f, 12'hf60};

  rsso_exec i_rsso_exec (.clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .wakeWatchdog(wakeWatchdog),
    .wakeOther(wakeOther), .watchdogClear(watchdogClear), .oscRun(oscRun));

  // 50 ns core clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // count clear pulses; hang guard sized well above the expected run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (rst) clearCount <= 4'h0;
    else if (watchdogClear === 1'b1) clearCount <= clearCount + 4'h1;
    if (cycles == 6000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    if (mismatches == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // request held until the rising edge that sees waitrequest low; one idle edge keeps strobes from merging
  task automatic busWrite(input logic [5:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    do @(posedge clk_sys); while (avsWaitrequest !== 1'b0);
    avsWrite <= 1'b0;
    @(posedge clk_sys);
  endtask

  // read data taken at the same edge that sees waitrequest low
  task automatic busRead(input logic [5:0] a);
    avsAddress <= a;
    avsRead <= 1'b1;
    do @(posedge clk_sys); while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsRead <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdChk(input logic [5:0] a, input logic [31:0] e);
    busRead(a);
    `CHK(rd, e)
  endtask

  task automatic setMem(input logic [11:0] a, input logic [7:0] v);
    busWrite(rsso_pkg::OFS_MEMADDR, {20'h0, a});
    busWrite(rsso_pkg::OFS_MEMDATA, {24'h0, v});
  endtask

  task automatic memChk(input logic [11:0] a, input logic [7:0] e);
    busWrite(rsso_pkg::OFS_MEMADDR, {20'h0, a});
    rdChk(rsso_pkg::OFS_MEMDATA, {24'h0, e});
  endtask

  // result is visible from the fifth cycle after the word is taken
  task automatic exec(input logic [15:0] ins);
    busWrite(rsso_pkg::OFS_INSTR, {16'h0, ins});
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic wakePulse(input logic wd);
    wakeWatchdog <= wd;
    wakeOther <= !wd;
    @(posedge clk_sys);
    wakeWatchdog <= 1'b0;
    wakeOther <= 1'b0;
    @(posedge clk_sys);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    avsAddress = 6'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    avsByteenable = 4'hf;
    wakeWatchdog = 1'b0;
    wakeOther = 1'b0;
    cases = '{
      '{16'h4205, 8'h33, 8'hd7, 5'h01, 8'h33, 8'heb, 5'h11},
      '{16'h4005, 8'h33, 8'hd7, 5'h01, 8'heb, 8'hd7, 5'h11},
      '{16'h4205, 8'h33, 8'h00, 5'h1f, 8'h33, 8'h00, 5'h0f},
      '{16'h6805, 8'h33, 8'h5a, 5'h0a, 8'h33, 8'hff, 5'h0a},
      '{16'h5e05, 8'h02, 8'h03, 5'h00, 8'h02, 8'h01, 5'h03},
      '{16'h5c05, 8'h02, 8'h02, 5'h00, 8'h00, 8'h02, 5'h07},
      '{16'h5e05, 8'h02, 8'h01, 5'h00, 8'h02, 8'hff, 5'h10},
      '{16'h5c05, 8'h01, 8'h80, 5'h00, 8'h7f, 8'h80, 5'h09},
      '{16'h5605, 8'h02, 8'h03, 5'h01, 8'h02, 8'hff, 5'h10},
      '{16'h5405, 8'h05, 8'h01, 5'h00, 8'h03, 8'h01, 5'h03},
      '{16'h0802, 8'h01, 8'h44, 5'h00, 8'h01, 8'h44, 5'h03},
      '{16'h0802, 8'h03, 8'h44, 5'h00, 8'hff, 8'h44, 5'h10},
      '{16'h0802, 8'h02, 8'h44, 5'h1f, 8'h00, 8'h44, 5'h07}};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdChk(rsso_pkg::OFS_POWER, 32'h3);
    busWrite(rsso_pkg::OFS_POWER, 32'hff);
    rdChk(rsso_pkg::OFS_POWER, 32'h3);
    rdChk(6'h24, 32'h0);
    rdChk(6'h02, 32'h0);
    // datapath table, operand at access-bank address 0x005
    foreach (cases[i]) begin
      setMem(12'h005, cases[i].fv);
      busWrite(rsso_pkg::OFS_ACC, {24'h0, cases[i].acc});
      busWrite(rsso_pkg::OFS_STATUS, {27'h0, cases[i].st});
      exec(cases[i].ins);
      rdChk(rsso_pkg::OFS_ACC, {24'h0, cases[i].eAcc});
      memChk(12'h005, cases[i].eFile);
      rdChk(rsso_pkg::OFS_STATUS, {27'h0, cases[i].eSt});
    end
    // bank select, high access bank and indexed offset
    busWrite(rsso_pkg::OFS_BANK, 32'h2);
    busWrite(rsso_pkg::OFS_CTRL, 32'h1);
    busWrite(rsso_pkg::OFS_INDEX, 32'h100);
    setMem(12'h05f, 8'h11);
    foreach (adrIns[i]) begin
      setMem(adrTgt[i], 8'h00);
      exec(adrIns[i]);
      memChk(adrTgt[i], 8'hff);
    end
    memChk(12'h05f, 8'h11);
    busWrite(rsso_pkg::OFS_CTRL, 32'h0);
    exec(16'h685f);
    memChk(12'h05f, 8'hff);
    // a write issued mid-instruction stalls until the cycle ends
    busWrite(rsso_pkg::OFS_ACC, 32'h3);
    busWrite(rsso_pkg::OFS_INSTR, 32'h0802);
    busWrite(rsso_pkg::OFS_ACC, 32'h44);
    rdChk(rsso_pkg::OFS_ACC, 32'h44);
    rdChk(rsso_pkg::OFS_STATUS, 32'h10);
    // sleep, dropped instruction, wake by other source then by watchdog
    exec(rsso_pkg::OPC_SLEEP);
    `CHK(oscRun, 1'b0)
    rdChk(rsso_pkg::OFS_POWER, 32'h6);
    `CHK(clearCount, 4'h1)
    setMem(12'h005, 8'h21);
    exec(16'h6805);
    wakePulse(1'b0);
    `CHK(oscRun, 1'b1)
    rdChk(rsso_pkg::OFS_POWER, 32'h2);
    memChk(12'h005, 8'h21);
    exec(rsso_pkg::OPC_SLEEP);
    rdChk(rsso_pkg::OFS_POWER, 32'h6);
    wakePulse(1'b1);
    rdChk(rsso_pkg::OFS_POWER, 32'h0);
    `CHK(clearCount, 4'h2)
    results();
  end
endmodule
